// *** pkg/crf_pkg.sv ***
// Shared constants and types for the core register file block.
package crf_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int CRF_NREG  = 32;
   localparam int CRF_PCW   = 9;
   localparam int CRF_DEPTH = 3;
   localparam int CRF_NIRQ  = 8;

   // ----------------------------------------
   // Addresses and reset values
   // ----------------------------------------
   localparam logic [4:0] CRF_ZLO_IDX   = 5'h1E;
   localparam logic [4:0] CRF_ZHI_IDX   = 5'h1F;
   localparam logic [4:0] CRF_UPPER     = 5'h10;
   localparam logic [5:0] CRF_STATUS_IO = 6'h3F;
   localparam logic [7:0] CRF_IO_BASE   = 8'h20;
   localparam logic [7:0] CRF_IO_END    = 8'h60;
   localparam logic [8:0] CRF_PC_RST    = 9'h000;
   localparam logic [8:0] CRF_PC_ONE    = 9'h001;
   localparam logic [7:0] CRF_STAT_RST  = 8'h00;
   localparam int CRF_SF_C = 0;
   localparam int CRF_SF_Z = 1;
   localparam int CRF_SF_N = 2;
   localparam int CRF_SF_I = 7;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      CRF_OP_NOP = 4'h0, CRF_OP_RR = 4'h1, CRF_OP_RI = 4'h2, CRF_OP_R1 = 4'h3,
      CRF_OP_LOAD_IMMEDIATE = 4'h4, CRF_OP_LDZ = 4'h5, CRF_OP_STZ = 4'h6, CRF_OP_CONSTANT_LOAD = 4'h7,
      CRF_OP_IN = 4'h8, CRF_OP_OUT = 4'h9, CRF_OP_RELATIVE_JUMP = 4'hA, CRF_OP_RELATIVE_CALL = 4'hB,
      CRF_OP_RET = 4'hC, CRF_OP_INTERRUPT_RETURN = 4'hD, CRF_OP_SEI = 4'hE, CRF_OP_CLI = 4'hF
   } crf_op_e;
   typedef enum logic [3:0] {
      CRF_FN_ADD = 4'h0, CRF_FN_ADC = 4'h1, CRF_FN_SUB = 4'h2, CRF_FN_SUB_CARRY = 4'h3,
      CRF_FN_AND = 4'h4, CRF_FN_OR = 4'h5, CRF_FN_EOR = 4'h6, CRF_FN_MOV = 4'h7,
      CRF_FN_COMPARE = 4'h8, CRF_FN_CPC = 4'h9, CRF_FN_COM = 4'hA, CRF_FN_INC = 4'hB,
      CRF_FN_DEC = 4'hC, CRF_FN_LSR = 4'hD
   } crf_fn_e;
   typedef enum logic [1:0] {
      CRF_ST_EXEC = 2'b00, CRF_ST_CONST_LOAD = 2'b01, CRF_ST_IO = 2'b10
   } crf_state_e;
   typedef struct packed {
      crf_op_e     op;
      crf_fn_e     fn;
      logic [4:0]  rd;
      logic [4:0]  rr;
      logic [7:0]  imm;
      logic [11:0] koff;
      logic [5:0]  ioa;
   } crf_dec_s;
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic       we;
      logic       re;
   } crf_io_s;
endpackage

// *** rtl/crf_core.sv ***
// Register file, fetch pipeline, return stack and interrupt entry of the core.
// What this block does
// RULE_01: Thirty-two byte registers, each reachable in one cycle.
// RULE_02: Two operands read, operated on and written back in one cycle.
// RULE_03: Immediate ops and load-immediate only target registers 16 to 31.
// RULE_04: Register and single-register ops reach every register.
// RULE_05: Registers 30 and 31 form the 16-bit indirect pointer.
// RULE_06: Indirect register access uses only the pointer low byte.
// RULE_07: Pointer reaches register file, I/O space and program memory.
// RULE_08: Next instruction prefetched while current one executes.
// RULE_09: Each instruction is one 16-bit word at one address.
// RULE_10: Relative jump and call reach the whole program space.
// RULE_11: Return address saved in a three-entry hardware stack.
// RULE_12: I/O space has 64 addresses.
// RULE_13: Global interrupt enable bit lives in the status register.
// RULE_14: Each interrupt source has its own vector at memory start.
// RULE_15: Lowest vector wins when several interrupts pend.
// RULE_16: ALU takes register pairs, constant-register pairs and single registers.
// RULE_17: Program counter and stack entries are nine bits wide.
// RULE_18: Push into entry 0 shifting deeper; pop entry 0 shifting up.
// RULE_19: Overflow drops oldest; deepest entry keeps its value on pop.
// RULE_20: Constant load: upper pointer bits pick word, bit 0 picks byte.
// RULE_21: Two read ports, one write port written at the cycle's edge.
// RULE_22: Interrupt taken only with global enable and source mask set.
`timescale 1ns/1ns
module crf_core
   import crf_pkg::*;
(
   input  wire logic                         sys_clk,       // System clock, 50 MHz.
   input  wire logic                         reset,         // Synchronous reset, active high.
   input  wire logic [15:0]                  pm_rdata,      // Program word at pm_addr_q.
   input  wire crf_pkg::crf_dec_s            dec,           // Decoder view of instr_q.
   input  wire logic [7:0]                   io_rdata,      // I/O read data, taken in the cycle re stands.
   input  wire logic [crf_pkg::CRF_NIRQ-1:0] irq_req,       // Interrupt request levels.
   input  wire logic [crf_pkg::CRF_NIRQ-1:0] irq_mask,      // Per-source enables.
   output logic [crf_pkg::CRF_PCW-1:0]       pm_addr_q,     // Fetch address.
   output logic [15:0]                       instr_q,       // Prefetched instruction.
   output logic                              instr_valid_q, // instr_q may execute.
   output logic [crf_pkg::CRF_PCW-1:0]       pc_q,          // Address of instr_q.
   output crf_pkg::crf_io_s                  io_q,          // I/O space access.
   output logic [crf_pkg::CRF_NIRQ-1:0]      irq_ack_q,     // One-hot accepted source.
   output logic [7:0]                        status_q       // Status flags.
);
   import crf_pkg::*;

   // ----------------------------------------
   // Storage and state
   // ----------------------------------------
   logic [7:0]         gpr_q   [CRF_NREG];
   // RULE_17 nine-bit entries
   logic [8:0]         stack_q [CRF_DEPTH];
   logic [8:0]         up_src  [CRF_DEPTH];
   logic [8:0]         dn_src  [CRF_DEPTH];
   crf_state_e         state_q;
   crf_state_e         state_d;
   logic [8:0]         ret_q;
   logic [4:0]         pend_rd_q;
   logic               const_hi_q;

   logic               exec;
   logic [4:0]         dst;
   logic [7:0]         opa;
   logic [7:0]         opb;
   logic [15:0]        zptr;
   logic [7:0]         zlo;
   logic               ind_reg;
   logic               ind_io;
   logic [5:0]         tio;
   logic               io_acc;
   logic               stat_hit;
   logic               io_rd;
   logic               io_wr;
   logic [CRF_NIRQ-1:0] pend;
   logic [CRF_NIRQ-1:0] sel;
   logic [8:0]         vec;
   logic               irq_take;
   logic               run;
   logic [8:0]         sum9;
   logic [7:0]         alu_res;
   logic               alu_c;
   logic               alu_wr;
   logic               wr_en;
   logic [4:0]         wr_addr;
   logic [7:0]         wr_data;
   logic [8:0]         rel_tgt;
   logic [8:0]         pm_d;
   logic               load_instr;
   logic               flush;
   logic               push;
   logic               pop;
   logic [8:0]         push_val;

   // ----------------------------------------
   // Operand selection
   // ----------------------------------------
   // Immediate forms carry only four register bits, so they land in the upper half.
   // RULE_03 upper half only
   // RULE_04 others reach all
   assign dst  = (dec.op == CRF_OP_RI || dec.op == CRF_OP_LOAD_IMMEDIATE)
               ? (CRF_UPPER | {1'b0, dec.rd[3:0]}) : dec.rd;
   // RULE_16 operand pair kinds
   assign opa  = gpr_q[dst];
   assign opb  = (dec.op == CRF_OP_RI) ? dec.imm : gpr_q[dec.rr];
   // RULE_05 pointer pair
   assign zptr = {gpr_q[CRF_ZHI_IDX], gpr_q[CRF_ZLO_IDX]};
   // RULE_06 low byte only
   assign zlo  = zptr[7:0];

   // Indirect data space: registers first, then the I/O window, above that nothing.
   // RULE_07 pointer targets
   assign ind_reg  = zlo < CRF_IO_BASE;
   assign ind_io   = !ind_reg && zlo < CRF_IO_END;
   // RULE_12 six-bit I/O address
   assign tio      = (dec.op == CRF_OP_IN || dec.op == CRF_OP_OUT)
                   ? dec.ioa : 6'(zlo - CRF_IO_BASE);
   assign io_acc   = dec.op == CRF_OP_IN || dec.op == CRF_OP_OUT
                   || ((dec.op == CRF_OP_LDZ || dec.op == CRF_OP_STZ) && ind_io);
   // RULE_13 status in I/O space
   assign stat_hit = io_acc && tio == CRF_STATUS_IO;

   // ----------------------------------------
   // Interrupt selection
   // ----------------------------------------
   // RULE_22 enable and mask
   assign pend     = irq_req & irq_mask;
   assign exec     = instr_valid_q && state_q == CRF_ST_EXEC;
   assign irq_take = exec && status_q[CRF_SF_I] && (|pend);
   assign run      = exec && !irq_take;
   // RULE_15 lowest vector wins
   assign sel      = pend & (~pend + 1'b1);

   // Vector 0 is reset, so source n enters at n plus one.
   always_comb
   begin
      vec = CRF_PC_RST;
      for (int i = CRF_NIRQ - 1; i >= 0; i--)
      begin
         // RULE_14 vector per source
         if (pend[i])
            vec = 9'(i + 1);
      end
   end

   assign io_rd = run && !stat_hit && (dec.op == CRF_OP_IN || (dec.op == CRF_OP_LDZ && ind_io));
   assign io_wr = run && !stat_hit && (dec.op == CRF_OP_OUT || (dec.op == CRF_OP_STZ && ind_io));

   // ----------------------------------------
   // ALU
   // ----------------------------------------
   // Compares reuse the subtractor and simply skip the write.
   always_comb
   begin
      sum9    = 9'h000;
      alu_res = opa;
      alu_c   = status_q[CRF_SF_C];
      alu_wr  = 1'b1;
      case (dec.fn)
         CRF_FN_ADD: sum9 = {1'b0, opa} + {1'b0, opb};
         CRF_FN_ADC: sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, status_q[CRF_SF_C]};
         CRF_FN_SUB, CRF_FN_COMPARE: sum9 = {1'b0, opa} - {1'b0, opb};
         CRF_FN_SUB_CARRY, CRF_FN_CPC: sum9 = {1'b0, opa} - {1'b0, opb} - {8'h00, status_q[CRF_SF_C]};
         default: sum9 = 9'h000;
      endcase
      case (dec.fn)
         CRF_FN_ADD, CRF_FN_ADC, CRF_FN_SUB, CRF_FN_SUB_CARRY:
         begin
            alu_res = sum9[7:0];
            alu_c   = sum9[8];
         end
         CRF_FN_COMPARE, CRF_FN_CPC:
         begin
            alu_res = sum9[7:0];
            alu_c   = sum9[8];
            alu_wr  = 1'b0;
         end
         CRF_FN_AND: alu_res = opa & opb;
         CRF_FN_OR:  alu_res = opa | opb;
         CRF_FN_EOR: alu_res = opa ^ opb;
         CRF_FN_MOV: alu_res = opb;
         CRF_FN_COM: alu_res = ~opa;
         CRF_FN_INC: alu_res = opa + 8'h01;
         CRF_FN_DEC: alu_res = opa - 8'h01;
         CRF_FN_LSR:
         begin
            alu_res = {1'b0, opa[7:1]};
            alu_c   = opa[0];
         end
         default: alu_res = opa;
      endcase
   end

   // ----------------------------------------
   // Write port
   // ----------------------------------------
   // Wait states own the port, so a stalled load never collides with an ALU write.
   always_comb
   begin
      wr_en   = 1'b0;
      wr_addr = dst;
      wr_data = alu_res;
      if (state_q == CRF_ST_CONST_LOAD)
      begin
         // RULE_20 byte select
         wr_en   = 1'b1;
         wr_addr = pend_rd_q;
         wr_data = const_hi_q ? pm_rdata[15:8] : pm_rdata[7:0];
      end
      else if (state_q == CRF_ST_IO)
      begin
         wr_en   = 1'b1;
         wr_addr = pend_rd_q;
         wr_data = io_rdata;
      end
      else if (run)
      begin
         case (dec.op)
            // RULE_02 single-cycle write back
            CRF_OP_RR, CRF_OP_RI, CRF_OP_R1: wr_en = alu_wr;
            CRF_OP_LOAD_IMMEDIATE:
            begin
               wr_en   = 1'b1;
               wr_data = dec.imm;
            end
            CRF_OP_LDZ:
            begin
               wr_en   = ind_reg || stat_hit || !ind_io;
               wr_data = ind_reg ? gpr_q[zlo[4:0]] : (stat_hit ? status_q : 8'h00);
            end
            CRF_OP_IN:
            begin
               wr_en   = stat_hit;
               wr_data = status_q;
            end
            CRF_OP_STZ:
            begin
               wr_en   = ind_reg;
               wr_addr = zlo[4:0];
               wr_data = gpr_q[dec.rd];
            end
            default: wr_en = 1'b0;
         endcase
      end
   end

   // One flop group per register; any of them can be read or written each cycle.
   for (genvar g = 0; g < CRF_NREG; g++)
   begin : g_gpr
      // RULE_01 register storage
      always_ff @(posedge sys_clk)
      begin
         if (reset)
            gpr_q[g] <= 8'h00;
         // RULE_21 write at edge
         else if (wr_en && wr_addr == 5'(g))
            gpr_q[g] <= wr_data;
      end
   end

   // ----------------------------------------
   // Fetch pipeline
   // ----------------------------------------
   // Nine-bit wrap lets any offset reach every word.
   // RULE_10 wrapping target
   assign rel_tgt = pc_q + dec.koff[8:0] + CRF_PC_ONE;

   always_comb
   begin
      pm_d       = pm_addr_q + CRF_PC_ONE;
      load_instr = 1'b1;
      flush      = 1'b0;
      state_d    = CRF_ST_EXEC;
      if (state_q != CRF_ST_EXEC)
      begin
         pm_d       = ret_q;
         load_instr = 1'b0;
      end
      else if (irq_take)
      begin
         pm_d  = vec;
         flush = 1'b1;
      end
      else if (run)
      begin
         case (dec.op)
            CRF_OP_RELATIVE_JUMP, CRF_OP_RELATIVE_CALL:
            begin
               pm_d  = rel_tgt;
               flush = 1'b1;
            end
            CRF_OP_RET, CRF_OP_INTERRUPT_RETURN:
            begin
               pm_d  = stack_q[0];
               flush = 1'b1;
            end
            CRF_OP_CONSTANT_LOAD:
            begin
               // RULE_20 word select
               pm_d    = zptr[CRF_PCW:1];
               state_d = CRF_ST_CONST_LOAD;
            end
            default: pm_d = pm_addr_q + CRF_PC_ONE;
         endcase
         if (io_rd)
            state_d = CRF_ST_IO;
      end
   end

   // The word fetched under a taken branch is already stale, so it is marked dead.
   // RULE_08 prefetch overlap
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pm_addr_q     <= CRF_PC_RST;
         instr_q       <= 16'h0000;
         instr_valid_q <= 1'b0;
         pc_q          <= CRF_PC_RST;
         state_q       <= CRF_ST_EXEC;
      end
      else
      begin
         pm_addr_q <= pm_d;
         state_q   <= state_d;
         if (load_instr)
         begin
            // RULE_09 one word each
            instr_q       <= pm_rdata;
            pc_q          <= pm_addr_q;
            instr_valid_q <= !flush;
         end
      end
   end

   // Stalled loads remember where to resume and which register to fill.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ret_q     <= CRF_PC_RST;
         pend_rd_q <= 5'h00;
         const_hi_q <= 1'b0;
      end
      else if (run)
      begin
         ret_q     <= pm_addr_q + CRF_PC_ONE;
         pend_rd_q <= dst;
         const_hi_q <= zptr[0];
      end
   end

   // ----------------------------------------
   // Return stack
   // ----------------------------------------
   // An interrupt returns to the squashed instruction, a call to the next one.
   assign push     = irq_take || (run && dec.op == CRF_OP_RELATIVE_CALL);
   assign pop      = run && (dec.op == CRF_OP_RET || dec.op == CRF_OP_INTERRUPT_RETURN);
   assign push_val = irq_take ? pc_q : pc_q + CRF_PC_ONE;

   for (genvar g = 0; g < CRF_DEPTH; g++)
   begin : g_stack
      if (g == 0)
         assign up_src[g] = push_val;
      else
         assign up_src[g] = stack_q[g-1];
      // RULE_19 deepest entry sticks
      if (g == CRF_DEPTH - 1)
         assign dn_src[g] = stack_q[g];
      else
         assign dn_src[g] = stack_q[g+1];
      // RULE_11 three-entry stack
      always_ff @(posedge sys_clk)
      begin
         if (reset)
            stack_q[g] <= CRF_PC_RST;
         // RULE_18 shift on push and pop
         else if (push)
            stack_q[g] <= up_src[g];
         else if (pop)
            stack_q[g] <= dn_src[g];
      end
   end

   // ----------------------------------------
   // Status, I/O and acknowledge
   // ----------------------------------------
   // Entry clears the global enable so a level request cannot re-enter at once.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         status_q <= CRF_STAT_RST;
      else if (irq_take)
         status_q[CRF_SF_I] <= 1'b0;
      else if (run)
      begin
         case (dec.op)
            // RULE_13 global enable
            CRF_OP_SEI, CRF_OP_INTERRUPT_RETURN: status_q[CRF_SF_I] <= 1'b1;
            CRF_OP_CLI: status_q[CRF_SF_I] <= 1'b0;
            CRF_OP_RR, CRF_OP_RI, CRF_OP_R1:
            begin
               status_q[CRF_SF_C] <= alu_c;
               status_q[CRF_SF_Z] <= alu_res == 8'h00;
               status_q[CRF_SF_N] <= alu_res[7];
            end
            CRF_OP_OUT, CRF_OP_STZ:
               if (stat_hit)
                  status_q <= gpr_q[dec.rd];
            default: status_q <= status_q;
         endcase
      end
   end

   // RULE_22 accepted source
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         io_q      <= '0;
         irq_ack_q <= '0;
      end
      else
      begin
         io_q.we    <= io_wr;
         io_q.re    <= io_rd;
         io_q.addr  <= tio;
         io_q.wdata <= gpr_q[dec.rd];
         irq_ack_q  <= irq_take ? sel : '0;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_const_issue;
      run && dec.op == CRF_OP_CONSTANT_LOAD;
   endsequence

   a_imm_upper_half: assert property ((run && dec.op == CRF_OP_LOAD_IMMEDIATE) |-> wr_en && wr_addr[4]) // RULE_03
      else $error("immediate load left upper half");
   a_alu_write_back: assert property ((run && dec.op == CRF_OP_RR && alu_wr)
      |=> gpr_q[$past(dst)] == $past(alu_res)) // RULE_02
      else $error("alu result not written back");
   a_ind_low_byte: assert property ((run && dec.op == CRF_OP_STZ && ind_reg)
      |=> gpr_q[$past(zlo[4:0])] == $past(gpr_q[dec.rd])) // RULE_06
      else $error("indirect store missed target");
   a_stack_push: assert property ((run && dec.op == CRF_OP_RELATIVE_CALL && !irq_take)
      |=> stack_q[0] == $past(pc_q) + CRF_PC_ONE && stack_q[2] == $past(stack_q[1])) // RULE_18
      else $error("call push wrong");
   a_stack_pop_keep: assert property (pop |=> stack_q[1] == $past(stack_q[2])
      && stack_q[2] == $past(stack_q[2])) // RULE_19
      else $error("pop did not keep deepest entry");
   a_irq_lowest: assert property (irq_take |=> irq_ack_q == $past(sel) && pm_addr_q == $past(vec)
      && !instr_valid_q) // RULE_15
      else $error("interrupt priority or vector wrong");
   a_irq_gate: assert property (!status_q[CRF_SF_I] |=> irq_ack_q == '0) // RULE_22
      else $error("interrupt taken while disabled");
   a_fetch_next: assert property ((run && dec.op == CRF_OP_NOP)
      |=> pm_addr_q == $past(pm_addr_q) + CRF_PC_ONE && pc_q == $past(pm_addr_q)) // RULE_08
      else $error("prefetch did not advance");
   a_jump_target: assert property ((run && dec.op == CRF_OP_RELATIVE_JUMP)
      |=> pm_addr_q == $past(pc_q) + $past(dec.koff[8:0]) + CRF_PC_ONE) // RULE_10
      else $error("relative target wrong");
   a_const_byte: assert property (s_const_issue |=> state_q == CRF_ST_CONST_LOAD
      ##1 state_q == CRF_ST_EXEC && gpr_q[$past(pend_rd_q)] == $past(wr_data)) // RULE_20
      else $error("constant load not completed");
endmodule

// *** testbench/crf_partner.sv ***
// Program memory, decoder and I/O space model facing the core.
`timescale 1ns/1ns
module crf_partner
   import crf_pkg::*;
(
   input  wire logic              sys_clk,  // System clock.
   input  wire logic [8:0]        pm_addr,  // Fetch address.
   input  wire logic [15:0]       instr,    // Word in execute.
   input  wire crf_pkg::crf_io_s  io,       // I/O access.
   output logic [15:0]            pm_rdata, // Program word.
   output crf_pkg::crf_dec_s      dec,      // Decoded fields.
   output logic [7:0]             io_rdata  // I/O read data.
);
   logic [15:0] pm [512];
   crf_dec_s    tab [512];
   logic [7:0]  iom [64];

   // Low nine bits of a word index the decode table, so every word stands alone.
   assign pm_rdata = pm[pm_addr];
   assign dec      = tab[instr[8:0]];

   // The core takes read data in the cycle its strobe stands, so it is answered at once.
   // Off the strobe the inverse shows, so a late sample never passes as good data.
   assign io_rdata = io.re ? iom[io.addr] : ~iom[io.addr];

   always @(posedge sys_clk)
   begin
      if (io.we)
         iom[io.addr] <= io.wdata;
   end
endmodule

// *** testbench/crf_core_tb.sv ***
// Self-checking bench for the core register file block.
`timescale 1ns/1ns
module crf_core_tb;
   import crf_pkg::*;
   logic        sys_clk;
   logic        reset;
   logic [7:0]  irq_req;
   logic [7:0]  irq_mask;
   logic [15:0] pm_rdata;
   crf_dec_s    dec;
   logic [7:0]  io_rdata;
   logic [8:0]  pm_addr_q;
   logic [15:0] instr_q;
   logic        instr_valid_q;
   logic [8:0]  pc_q;
   crf_io_s     io_q;
   logic [7:0]  irq_ack_q;
   logic [7:0]  status_q;
   int          n_mismatch;
   int          checks_done;
   integer      seed;
   logic [13:0] q_io[$];
   logic [17:0] q_ack[$];
   logic [7:0]  q_loop[$];
   logic [7:0]  a;
   logic [7:0]  b;
   int          i;

   crf_core u_crf_core (.sys_clk(sys_clk), .reset(reset), .pm_rdata(pm_rdata), .dec(dec),
      .io_rdata(io_rdata), .irq_req(irq_req), .irq_mask(irq_mask), .pm_addr_q(pm_addr_q),
      .instr_q(instr_q), .instr_valid_q(instr_valid_q), .pc_q(pc_q), .io_q(io_q), .irq_ack_q(irq_ack_q),
      .status_q(status_q));
   crf_partner u_crf_partner (.sys_clk(sys_clk), .pm_addr(pm_addr_q), .instr(instr_q), .io(io_q),
      .pm_rdata(pm_rdata), .dec(dec), .io_rdata(io_rdata));

   // ------
   // Tasks
   // ------
   task automatic put(input int at, input crf_op_e op, input crf_fn_e fn, input int rd, input int rr,
                      input int v, input int ioa);
      u_crf_partner.tab[at] = '{op, fn, 5'(rd), 5'(rr), 8'(v), 12'(v), 6'(ioa)};
   endtask

   task automatic bad(input string m);
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
   endtask

   task automatic cmp_io(input logic [13:0] got, input logic [13:0] exp);
      checks_done++;
      if (got !== exp)
         bad($sformatf("io write %h expected %h", got, exp));
   endtask

   // Acknowledge, the dead slot and the vector address are compared together.
   task automatic cmp_ack(input logic [17:0] got, input logic [17:0] exp);
      checks_done++;
      if (got !== exp)
         bad($sformatf("ack %h expected %h", got, exp));
   endtask

   task automatic cmp_flag(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
         bad($sformatf("flag %b expected %b", got, exp));
   endtask

   task automatic results;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A bounded wait for all notes to be consumed; running out ends the run.
   task automatic settle(input int lim);
      for (int k = 0; k < lim && (q_io.size() || q_ack.size() || q_loop.size()); k++)
         @(negedge sys_clk);
      if (q_io.size() || q_ack.size() || q_loop.size())
      begin
         bad("timeout");
         results();
      end
   endtask

   // ------
   // Clock, watcher and stimulus
   // ------
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // Outputs are registered, so they are settled at the falling edge.
   always @(negedge sys_clk)
      if (reset === 1'b0)
      begin
         if (io_q.we === 1'b1 && io_q.addr === 6'h33)
         begin
            if (q_loop.size())
               cmp_io({io_q.addr, io_q.wdata}, {6'h33, q_loop.pop_front()});
         end
         else if (io_q.we === 1'b1)
            cmp_io({io_q.addr, io_q.wdata}, q_io.size() ? q_io.pop_front() : 14'hx);
         if (irq_ack_q !== 8'h00)
         begin
            cmp_ack({irq_ack_q, instr_valid_q, pm_addr_q}, q_ack.size() ? q_ack.pop_front() : 18'hx);
            cmp_flag(status_q[CRF_SF_I], 1'b0);
         end
      end

   initial
   begin
      seed = 3;
      n_mismatch = 0;
      checks_done = 0;
      reset = 1'b1;
      irq_req = 8'h02;
      irq_mask = 8'h00;
      a = 8'($random(seed));
      b = 8'($random(seed));
      for (i = 0; i < 512; i++)
      begin
         u_crf_partner.pm[i] = {7'($random(seed)), 9'(i)};
         u_crf_partner.tab[i] = '0;
      end
      for (i = 1; i <= 8; i++)
         put(i, CRF_OP_INTERRUPT_RETURN, CRF_FN_ADD, 0, 0, 0, 0);
      // The jump lands on the empty word 15, so one idle instruction runs first.
      put(0, CRF_OP_RELATIVE_JUMP, CRF_FN_ADD, 0, 0, 14, 0);
      put(3, CRF_OP_OUT, CRF_FN_ADD, 17, 17, 0, 'h0B);
      put(16, CRF_OP_LOAD_IMMEDIATE, CRF_FN_ADD, 16, 16, a, 0);
      put(17, CRF_OP_LOAD_IMMEDIATE, CRF_FN_ADD, 17, 17, b, 0);
      put(18, CRF_OP_RR, CRF_FN_ADD, 16, 17, 0, 0);
      put(19, CRF_OP_OUT, CRF_FN_ADD, 16, 16, 0, 'h05);
      put(20, CRF_OP_RR, CRF_FN_MOV, 0, 17, 0, 0);
      put(21, CRF_OP_OUT, CRF_FN_ADD, 0, 0, 0, 'h06);
      put(22, CRF_OP_LOAD_IMMEDIATE, CRF_FN_ADD, 5, 5, 'h77, 0);
      put(23, CRF_OP_OUT, CRF_FN_ADD, 5, 5, 0, 'h07);
      put(24, CRF_OP_LOAD_IMMEDIATE, CRF_FN_ADD, 30, 30, 'h25, 0);
      put(25, CRF_OP_LOAD_IMMEDIATE, CRF_FN_ADD, 31, 31, 0, 0);
      put(26, CRF_OP_CONSTANT_LOAD, CRF_FN_ADD, 22, 22, 0, 0);
      put(27, CRF_OP_OUT, CRF_FN_ADD, 22, 22, 0, 'h0C);
      put(28, CRF_OP_LOAD_IMMEDIATE, CRF_FN_ADD, 30, 30, 'h03, 0);
      put(29, CRF_OP_LOAD_IMMEDIATE, CRF_FN_ADD, 31, 31, 'hAB, 0);
      put(30, CRF_OP_STZ, CRF_FN_ADD, 16, 16, 0, 0);
      put(31, CRF_OP_LDZ, CRF_FN_ADD, 23, 23, 0, 0);
      put(32, CRF_OP_OUT, CRF_FN_ADD, 23, 23, 0, 'h08);
      put(33, CRF_OP_IN, CRF_FN_ADD, 24, 24, 0, 'h05);
      put(34, CRF_OP_OUT, CRF_FN_ADD, 24, 24, 0, 'h0D);
      put(35, CRF_OP_SEI, CRF_FN_ADD, 0, 0, 0, 0);
      put(36, CRF_OP_RELATIVE_CALL, CRF_FN_ADD, 0, 0, 3, 0);
      // Four nested calls, then returns that each bump and show a counter.
      put(52, CRF_OP_RET, CRF_FN_ADD, 0, 0, 0, 0);
      for (i = 40; i <= 48; i += 4)
      begin
         put(i, CRF_OP_RELATIVE_CALL, CRF_FN_ADD, 0, 0, 3, 0);
         put(i + 1, CRF_OP_R1, CRF_FN_INC, 20, 20, 0, 0);
         put(i + 2, CRF_OP_OUT, CRF_FN_ADD, 20, 20, 0, 'h33);
         put(i + 3, CRF_OP_RET, CRF_FN_ADD, 0, 0, 0, 0);
      end
      q_io.push_back({6'h05, 8'(a + b)});
      q_io.push_back({6'h06, b});
      q_io.push_back({6'h07, 8'h00});
      q_io.push_back({6'h0C, u_crf_partner.pm[18][15:8]});
      q_io.push_back({6'h08, 8'(a + b)});
      q_io.push_back({6'h0D, 8'(a + b)});
      // Deepest entry repeats, so the counter keeps climbing in the last body.
      for (i = 1; i <= 40; i++)
         q_loop.push_back(8'(i));
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      settle(400);
      // Two sources at once with one masked source also pending.
      q_io.push_back({6'h0B, b});
      q_ack.push_back({8'h04, 1'b0, 9'h003});
      q_ack.push_back({8'h20, 1'b0, 9'h006});
      irq_req = 8'h26;
      irq_mask = 8'h24;
      for (i = 0; i < 100 && irq_ack_q !== 8'h04; i++)
         @(negedge sys_clk);
      irq_req = 8'h22;
      for (i = 0; i < 100 && irq_ack_q !== 8'h20; i++)
         @(negedge sys_clk);
      irq_req = 8'h02;
      settle(200);
      repeat (40) @(negedge sys_clk);
      cmp_flag(status_q[CRF_SF_I], 1'b1);
      results();
   end
endmodule
